/* bbse_addr_gen.sv */
// Data address generator for bit-oriented register access
`timescale 1ns/1ps
`include "bbse_regs.svh"
module bbse_addr_gen (
  // Address request and result
  bbse_addr_if.gen a
);

  // ==========================================================================
  // Address forming
  always_comb begin
    a.indexed = 1'b0;
    if (a.access_bit) begin
      a.phys_addr = {a.bank_ptr, a.f_addr};
    end else if (a.ext_en && (a.f_addr <= `BBSE_INDEXED_MAX)) begin
      // Indexed literal offset: base plus file field
      a.phys_addr = a.index_base + {4'h0, a.f_addr};
      a.indexed = 1'b1;
    end else if (a.f_addr < `BBSE_ACCESS_SPLIT) begin
      a.phys_addr = {4'h0, a.f_addr};
    end else begin
      // Upper part of the access bank maps onto the special registers
      a.phys_addr = {`BBSE_ACCESS_HIGH, a.f_addr};
    end
  end

endmodule

/* bbse_addr_if.sv */
// Interface between the executer and its data address generator
`timescale 1ns/1ps
interface bbse_addr_if;
  logic [7:0] f_addr;
  logic access_bit;
  logic [3:0] bank_ptr;
  logic ext_en;
  logic [11:0] index_base;
  logic [11:0] phys_addr;
  logic indexed;

  modport exec (output f_addr, access_bit, bank_ptr, ext_en, index_base, input phys_addr, indexed);
  modport gen (input f_addr, access_bit, bank_ptr, ext_en, index_base, output phys_addr, indexed);
endinterface

/* bbse_exec.sv */
// Branch and bit-set execution unit with APB register access
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "bbse_regs.svh"
module bbse_exec #(
  parameter int PC_W = 21
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction fetch
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  output logic instr_ready,
  output logic [PC_W-1:0] pc,
  output logic [1:0] qphase,
  // Status flags from the core
  input wire logic flag_zero,
  input wire logic flag_overflow,
  // Data memory
  output logic [11:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);

  // ==========================================================================
  // State
  bbse_pkg::bbse_phase_e phase_reg, phase_next;
  bbse_pkg::bbse_op_e op_reg, op_next;
  logic [15:0] ir_reg, ir_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic flush_reg, flush_next;
  logic [11:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic ext_reg, ext_next;
  logic [3:0] bank_reg, bank_next;
  logic [11:0] ibase_reg, ibase_next;
  logic unsup_reg, unsup_next;
  logic [7:0] tcnt_reg, tcnt_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;

  logic take;
  logic taken;
  logic apb_acc;
  logic apb_map;
  logic [PC_W-1:0] boff;
  logic [7:0] bmask;
  bbse_pkg::bbse_op_e dec;

  bbse_addr_if aif ();

  bbse_addr_gen u_addr (
    .a (aif)
  );

  // ==========================================================================
  // Decode of the word offered on the fetch port
  always_comb begin
    if (instr_word[15:8] == `BBSE_OP_BZC) begin
      dec = bbse_pkg::OP_BZC;
    end else if (instr_word[15:8] == `BBSE_OP_BOVC) begin
      dec = bbse_pkg::OP_BOVC;
    end else if (instr_word[15:11] == `BBSE_OP_JMP) begin
      dec = bbse_pkg::OP_JMP;
    end else if (instr_word[15:12] == `BBSE_OP_SETB) begin
      dec = bbse_pkg::OP_SETB;
    end else begin
      dec = bbse_pkg::OP_UNSUP;
    end
  end

  // A new word is taken only in Q1 of a cycle that is not a flush cycle
  assign take = ce && (phase_reg == bbse_pkg::Q1) && !flush_reg && instr_valid;
  assign instr_ready = ce && (phase_reg == bbse_pkg::Q1) && !flush_reg;

  // Address generator sees the word being taken so the address is ready in Q2
  // Fed from the fetch port rather than ir_next, so no process reads back what it drives
  assign aif.f_addr = instr_word[7:0];
  assign aif.access_bit = instr_word[8];
  assign aif.bank_ptr = bank_reg;
  assign aif.ext_en = ext_reg;
  assign aif.index_base = ibase_reg;

  // ==========================================================================
  // Branch condition and offset
  always_comb begin
    unique case (op_reg)
      bbse_pkg::OP_BZC: taken = !flag_zero;
      bbse_pkg::OP_BOVC: taken = !flag_overflow;
      bbse_pkg::OP_JMP: taken = 1'b1;
      default: taken = 1'b0;
    endcase
    // Offsets are word counts, so they are doubled into byte addresses
    if (op_reg == bbse_pkg::OP_JMP) begin
      boff = {{(PC_W-12){ir_reg[10]}}, ir_reg[10:0], 1'b0};
    end else begin
      boff = {{(PC_W-9){ir_reg[7]}}, ir_reg[7:0], 1'b0};
    end
    bmask = 8'h01 << ir_reg[11:9];
  end

  // ==========================================================================
  // APB decode
  assign apb_acc = psel && penable && ce;
  always_comb begin
    unique case (paddr)
      `BBSE_CTRL_OFF, `BBSE_BANK_OFF, `BBSE_IDXBASE_OFF, `BBSE_PC_OFF,
      `BBSE_STATUS_OFF: apb_map = 1'b1;
      default: apb_map = 1'b0;
    endcase
  end

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    phase_next = phase_reg;
    op_next = op_reg;
    ir_next = ir_reg;
    pc_next = pc_reg;
    flush_next = flush_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    tcnt_next = tcnt_reg;
    unsup_next = unsup_reg;
    if (ce) begin
      phase_next = bbse_pkg::bbse_phase_e'(phase_reg + 2'h1);
      unique case (phase_reg)
        bbse_pkg::Q1: begin
          if (flush_reg) begin
            // Second cycle of a taken branch does nothing in any phase
            flush_next = 1'b0;
            op_next = bbse_pkg::OP_NOP;
          end else if (take) begin
            ir_next = instr_word;
            op_next = dec;
            // From here the program counter points past this word
            pc_next = pc_reg + PC_W'(2);
            addr_next = aif.phys_addr;
          end else begin
            op_next = bbse_pkg::OP_NOP;
          end
        end
        bbse_pkg::Q2: begin
        end
        bbse_pkg::Q3: begin
          // Memory answers one clock after the Q2 read strobe
          data_next = mem_rdata | bmask;
        end
        bbse_pkg::Q4: begin
          if (taken) begin
            pc_next = pc_reg + boff;
            flush_next = 1'b1;
            tcnt_next = tcnt_reg + 8'h01;
          end
          if (op_reg == bbse_pkg::OP_UNSUP) begin
            unsup_next = 1'b1;
          end
        end
      endcase
    end
    // Software writes; a PC write redirects fetch and wins over the core
    if (apb_acc && pwrite && paddr == `BBSE_PC_OFF) begin
      pc_next = pwdata[PC_W-1:0];
    end
    // Set wins over the write-one clear
    if (apb_acc && pwrite && paddr == `BBSE_STATUS_OFF && pwdata[`BBSE_STATUS_UNSUP_BIT]) begin
      unsup_next = (ce && phase_reg == bbse_pkg::Q4 && op_reg == bbse_pkg::OP_UNSUP);
    end
  end

  // ==========================================================================
  // Register file next state
  always_comb begin
    ext_next = ext_reg;
    bank_next = bank_reg;
    ibase_next = ibase_reg;
    prdata_next = prdata_reg;
    // A low enable freezes the error flag along with the rest of the bus state
    pslverr_next = ce ? 1'b0 : pslverr_reg;
    if (psel && !penable && ce) begin
      // Read data is prepared in the setup cycle so the access phase answers at once
      prdata_next = 32'h00000000;
      unique case (paddr)
        `BBSE_CTRL_OFF: prdata_next[`BBSE_CTRL_EXT_BIT] = ext_reg;
        `BBSE_BANK_OFF: prdata_next[3:0] = bank_reg;
        `BBSE_IDXBASE_OFF: prdata_next[11:0] = ibase_reg;
        `BBSE_PC_OFF: prdata_next[PC_W-1:0] = pc_reg;
        `BBSE_STATUS_OFF: begin
          prdata_next[`BBSE_STATUS_FLUSH_BIT] = flush_reg;
          prdata_next[`BBSE_STATUS_UNSUP_BIT] = unsup_reg;
          prdata_next[`BBSE_STATUS_TCNT_LSB +: 8] = tcnt_reg;
        end
        default: prdata_next = 32'h00000000;
      endcase
      pslverr_next = !apb_map;
    end
    if (apb_acc) begin
      pslverr_next = pslverr_reg;
    end
    if (apb_acc && pwrite) begin
      unique case (paddr)
        `BBSE_CTRL_OFF: ext_next = pwdata[`BBSE_CTRL_EXT_BIT];
        `BBSE_BANK_OFF: bank_next = pwdata[3:0];
        `BBSE_IDXBASE_OFF: ibase_next = pwdata[11:0];
        default: ext_next = ext_reg;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_reg <= bbse_pkg::Q1;
      op_reg <= bbse_pkg::OP_NOP;
      ir_reg <= 16'h0000;
      pc_reg <= PC_W'(`BBSE_PC_RST);
      flush_reg <= 1'b0;
      addr_reg <= 12'h000;
      data_reg <= 8'h00;
      ext_reg <= `BBSE_CTRL_RST;
      bank_reg <= `BBSE_BANK_RST;
      ibase_reg <= `BBSE_IDXBASE_RST;
      unsup_reg <= 1'b0;
      tcnt_reg <= 8'h00;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      op_reg <= op_next;
      ir_reg <= ir_next;
      pc_reg <= pc_next;
      flush_reg <= flush_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      ext_reg <= ext_next;
      bank_reg <= bank_next;
      ibase_reg <= ibase_next;
      unsup_reg <= unsup_next;
      tcnt_reg <= tcnt_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // Outputs; status flags are never driven from here, so branches and bit set leave them
  assign pc = pc_reg;
  assign qphase = phase_reg;
  assign mem_addr = addr_reg;
  assign mem_rd = ce && phase_reg == bbse_pkg::Q2 && op_reg == bbse_pkg::OP_SETB;
  assign mem_wr = ce && phase_reg == bbse_pkg::Q4 && op_reg == bbse_pkg::OP_SETB;
  assign mem_wdata = data_reg;
  // A frozen block cannot finish a transfer, so pready follows the enable
  assign pready = ce;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && penable && ce;

endmodule

/* bbse_exec_properties.sv */
// Port-level checks of the branch and bit-set unit
`timescale 1ns/1ps
`include "bbse_regs.svh"
module bbse_exec_properties #(
  parameter int PC_W = 21
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Fetch and flags
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic instr_ready,
  input wire logic [PC_W-1:0] pc,
  input wire logic [1:0] qphase,
  input wire logic flag_zero,
  input wire logic flag_overflow,
  // Data memory
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata
);
  logic [15:0] cur_reg;
  logic [PC_W-1:0] base_reg;
  logic live_reg;
  logic take, jmp, bcond, endq4;
  logic [PC_W-1:0] t_jmp, t_br;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // ==========================================================================
  // Shadow of the instruction in flight; cleared at Q4 so a flush cycle never matches
  assign take = ce && instr_valid && instr_ready;
  assign jmp = cur_reg[15:11] == `BBSE_OP_JMP;
  assign bcond = (cur_reg[15:8] == `BBSE_OP_BZC && !flag_zero) ||
    (cur_reg[15:8] == `BBSE_OP_BOVC && !flag_overflow);
  assign endq4 = live_reg && ce && qphase == 2'b11;
  assign t_jmp = base_reg + {{(PC_W-12){cur_reg[10]}}, cur_reg[10:0], 1'b0};
  assign t_br = base_reg + {{(PC_W-9){cur_reg[7]}}, cur_reg[7:0], 1'b0};
  always_ff @(posedge sys_clk) begin
    if (take) begin
      cur_reg <= instr_word;
      base_reg <= pc + PC_W'(2);
    end
    if (srst || endq4) live_reg <= 1'b0;
    else if (take) live_reg <= 1'b1;
  end
  // ==========================================================================
  // Properties
  chk_ready_q1: assert property (instr_ready |-> ce && qphase == 2'b00)
    else $error("fetch offered outside Q1");
  chk_fetch_step: assert property (take && !(psel && pwrite && paddr == `BBSE_PC_OFF)
    |=> pc == $past(pc) + PC_W'(2))
    else $error("pc not incremented after fetch");
  chk_jump_target: assert property (endq4 && jmp |=> pc == t_jmp)
    else $error("relative jump target wrong");
  chk_branch_taken: assert property (endq4 && bcond && !jmp |=> pc == t_br)
    else $error("conditional branch target wrong");
  chk_branch_idle: assert property (endq4 && !bcond && !jmp
    |=> pc == $past(pc) && instr_ready)
    else $error("untaken instruction moved pc or stalled");
  chk_flush_len: assert property (endq4 && (bcond || jmp)
    |=> !instr_ready [*4] ##1 instr_ready)
    else $error("idle cycle after branch has wrong length");
  chk_setb_seq: assert property (take && instr_word[15:12] == `BBSE_OP_SETB
    |=> mem_rd && !mem_wr ##1 !mem_rd && !mem_wr ##1 mem_wr && !mem_rd)
    else $error("bit set access order wrong");
  chk_setb_data: assert property (mem_wr
    |-> mem_wdata == ($past(mem_rdata) | (8'h01 << cur_reg[11:9])))
    else $error("bit set write data wrong");
  chk_apb_unmap: assert property (psel && penable && ce && paddr > `BBSE_STATUS_OFF
    |-> pslverr && pready)
    else $error("unmapped access not flagged");
endmodule
bind bbse_exec bbse_exec_properties #(.PC_W(PC_W)) u_bbse_exec_properties (
  .sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
  .pc(pc), .qphase(qphase), .flag_zero(flag_zero), .flag_overflow(flag_overflow),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
);

/* bbse_pkg.sv */
// Types shared by the branch and bit-set unit
package bbse_pkg;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } bbse_phase_e;

  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_BZC = 3'b001,
    OP_BOVC = 3'b010,
    OP_JMP = 3'b011,
    OP_SETB = 3'b100,
    OP_UNSUP = 3'b101
  } bbse_op_e;

endpackage

/* bbse_regs.svh */
// Register offsets, field positions, reset values and opcode constants of the branch and bit-set unit
`ifndef BBSE_REGS_SVH
`define BBSE_REGS_SVH

// ==========================================================================
// Register byte offsets
`define BBSE_CTRL_OFF 12'h000
`define BBSE_BANK_OFF 12'h004
`define BBSE_IDXBASE_OFF 12'h008
`define BBSE_PC_OFF 12'h00c
`define BBSE_STATUS_OFF 12'h010

// ==========================================================================
// Field positions
`define BBSE_CTRL_EXT_BIT 0
`define BBSE_STATUS_FLUSH_BIT 0
`define BBSE_STATUS_UNSUP_BIT 1
`define BBSE_STATUS_TCNT_LSB 8

// ==========================================================================
// Reset values
`define BBSE_CTRL_RST 1'h0
`define BBSE_BANK_RST 4'h0
`define BBSE_IDXBASE_RST 12'h000
`define BBSE_PC_RST 21'h000000

// ==========================================================================
// Opcode patterns
`define BBSE_OP_BZC 8'he1
`define BBSE_OP_BOVC 8'he5
`define BBSE_OP_JMP 5'h1a
`define BBSE_OP_SETB 4'h8

// ==========================================================================
// Data address map
`define BBSE_ACCESS_SPLIT 8'h60
`define BBSE_INDEXED_MAX 8'h5f
`define BBSE_ACCESS_HIGH 4'hf

// ==========================================================================
// Timing: one instruction cycle is four quarter phases
`define BBSE_QPHASES 4

`endif

/* tb_top.sv */
// Self-checking bench of the branch and bit-set unit
`timescale 1ns/1ps
`include "bbse_regs.svh"
module tb_top;
  logic sys_clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0, mem_addr, wr_addr, exp_a, base;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, instr_ready, mem_rd, mem_wr, err, ext, pend = 0;
  logic instr_valid = 0, flag_zero = 0, flag_overflow = 0;
  logic [15:0] instr_word = '0, lf = 16'h000d, w;
  logic [15:0] corner [6] = '{16'h8e5f, 16'h8060, 16'hd400, 16'hd3ff, 16'he180, 16'he57f};
  logic [20:0] pc, pc_exp;
  logic [1:0] qphase;
  logic [3:0] bank;
  logic [7:0] mem_wdata, mem_rdata = '0, rd_byte = '0, wr_data, exp_d;
  int bad_count = 0, n_tests = 0, cyc = 0, n_taken = 0;
  bbse_exec u_bbse_exec (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .pc(pc), .qphase(qphase), .flag_zero(flag_zero),
    .flag_overflow(flag_overflow), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
  );
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ==========================================================================
  // Data memory: read data toggles outside the read slot so stale values show up
  always @(posedge sys_clk) begin
    mem_rdata <= mem_rd ? rd_byte : ~mem_rdata;
    if (mem_wr) begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  // ==========================================================================
  // Helpers
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [20:0] nxt_pc(input logic [20:0] p, input logic [15:0] x,
                                         input logic [1:0] fl);
    logic [20:0] t;
    t = p + 21'h2;
    if (x[15:11] == `BBSE_OP_JMP) return t + {{9{x[10]}}, x[10:0], 1'b0};
    if ((x[15:8] == `BBSE_OP_BZC && !fl[1]) || (x[15:8] == `BBSE_OP_BOVC && !fl[0]))
      return t + {{12{x[7]}}, x[7:0], 1'b0};
    return t;
  endfunction
  function automatic logic taken_f(input logic [15:0] x, input logic [1:0] fl);
    return (x[15:11] == `BBSE_OP_JMP) || (x[15:8] == `BBSE_OP_BZC && !fl[1]) ||
      (x[15:8] == `BBSE_OP_BOVC && !fl[0]);
  endfunction
  function automatic logic [11:0] exp_addr(input logic [15:0] x);
    if (x[8]) return {bank, x[7:0]};
    if (ext && x[7:0] <= `BBSE_INDEXED_MAX) return base + 12'(x[7:0]);
    if (x[7:0] < `BBSE_ACCESS_SPLIT) return {4'h0, x[7:0]};
    return {`BBSE_ACCESS_HIGH, x[7:0]};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Request stands until the edge that sees pready high; data is taken at that edge
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Flags and read data change only after the take, so the previous Q4 never sees them
  task automatic run(input logic [15:0] x, input logic [1:0] fl, input logic [7:0] rb);
    instr_word <= x;
    instr_valid <= 1'b1;
    do @(negedge sys_clk); while (instr_ready !== 1'b1);
    chk("pc", 32'(pc_exp), 32'(pc));
    if (pend) chk("wr_addr", 32'(exp_a), 32'(wr_addr));
    if (pend) chk("wr_data", 32'(exp_d), 32'(wr_data));
    pend = (x[15:12] == `BBSE_OP_SETB);
    exp_a = exp_addr(x);
    exp_d = rb | (8'h01 << x[11:9]);
    pc_exp = nxt_pc(pc_exp, x, fl);
    if (taken_f(x, fl)) n_taken++;
    @(posedge sys_clk);
    {flag_zero, flag_overflow} <= fl;
    rd_byte <= rb;
  endtask
  task automatic finish_test;
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset", 32'h0, rd);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    // Frozen block: phase and pc must hold and pready must be low while the enable is low
    ce <= 1'b0;
    @(negedge sys_clk);
    rd = {9'h0, qphase, pc};
    repeat (3) @(negedge sys_clk);
    chk("ce_hold", rd, {9'h0, qphase, pc});
    chk("ce_pready", 32'h0, 32'(pready));
    @(posedge sys_clk);
    ce <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      lf = nxt(lf);
      ext = (c == 2);
      bank = lf[3:0];
      base = lf[15:4];
      apb(1'b1, `BBSE_CTRL_OFF, {31'h0, ext});
      apb(1'b1, `BBSE_BANK_OFF, {28'h0, bank});
      apb(1'b1, `BBSE_IDXBASE_OFF, {20'h0, base});
      pc_exp = {4'h0, lf, 1'b0};
      apb(1'b1, `BBSE_PC_OFF, {11'h0, pc_exp});
      for (int k = 0; k < 14; k++) begin
        lf = nxt(lf);
        case (lf[1:0])
          2'd0: w = {`BBSE_OP_BZC, lf[15:8]};
          2'd1: w = {`BBSE_OP_BOVC, lf[15:8]};
          2'd2: w = {`BBSE_OP_JMP, lf[15:5]};
          default: w = {`BBSE_OP_SETB, lf[15:4]};
        endcase
        if (k < 6) w = corner[k];
        run(w, lf[3:2], lf[11:4]);
      end
      run(16'h0000, 2'b00, 8'h00);
      @(posedge sys_clk);
      instr_valid <= 1'b0;
    end
    apb(1'b0, `BBSE_STATUS_OFF, 32'h0);
    chk("sticky", 32'h1, 32'(rd[`BBSE_STATUS_UNSUP_BIT]));
    chk("taken_cnt", 32'(n_taken[7:0]), 32'(rd[15:8]));
    apb(1'b1, `BBSE_STATUS_OFF, 32'h2);
    apb(1'b0, `BBSE_STATUS_OFF, 32'h0);
    chk("unsup_clear", 32'h0, 32'(rd[`BBSE_STATUS_UNSUP_BIT]));
    finish_test();
  end
endmodule
